// file: common/psmc_consts.svh
// Purpose: constants for the power saving mode controller
// Assumes: 100 MHz system clock, retained time base tick from outside
// Notes:   timer values are counted in time base ticks
`ifndef PSMC_CONSTS_SVH
`define PSMC_CONSTS_SVH
`define PSMC_TMR_W        32
`define PSMC_TMR_ZERO     32'h00000000
`define PSMC_TMR_ONE      32'h00000001
`define PSMC_CLK_PERIOD_NS 10
`endif

// file: common/psmc_pkg.sv
// Purpose: types for the power saving mode controller
// Assumes: constants header included
// Notes:   state enum has no codes given
`include "psmc_consts.svh"
package psmc_pkg;
   typedef enum logic [2:0] {
      PSMC_DETACHED,
      PSMC_ATTACHING,
      PSMC_UPDATING,
      PSMC_IDLE,
      PSMC_DORMANT,
      PSMC_HIBERNATE,
      PSMC_CONNECTED
   } psmc_state_type;
   typedef logic [`PSMC_TMR_W-1:0] psmc_tmr_type;
endpackage

// file: common/psmc_tmr_if.sv
// Purpose: carrier between the controller and a timer
// Assumes: one clock domain
// Notes:   load restarts, expired is a one-cycle pulse
`timescale 1ns/1ps
interface psmc_tmr_if;
   import psmc_pkg::*;
   logic         load;
   logic         run;
   psmc_tmr_type value;
   logic         expired;
   modport ctrl (output load, output run, output value, input expired);
   modport tmr  (input load, input run, input value, output expired);
endinterface

// file: src/psmc_timer.sv
// Purpose: down counter on the retained time base
// Assumes: tick is a one-cycle pulse on the system clock
// Notes:   a zero value never expires
`timescale 1ns/1ps
`include "psmc_consts.svh"
module psmc_timer
   import psmc_pkg::*;
(
   input  wire logic i_sys_clk,
   input  wire logic i_rst_n,
   input  wire logic i_ce,
   input  wire logic i_tick,
   psmc_tmr_if.tmr   tif
);
   psmc_tmr_type cnt_q;
   logic         exp_q;

   // count down on ticks, restart on load
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q <= `PSMC_TMR_ZERO;
         exp_q <= 1'b0;
      end else if (i_ce) begin
         exp_q <= 1'b0;
         if (tif.load) begin
            cnt_q <= tif.value;
         end else if (tif.run && i_tick && cnt_q != `PSMC_TMR_ZERO) begin
            cnt_q <= cnt_q - `PSMC_TMR_ONE;
            exp_q <= (cnt_q == `PSMC_TMR_ONE);
         end
      end
   end
   assign tif.expired = exp_q;
endmodule // psmc_timer

// file: src/psmc_ctrl.sv
// Purpose: power saving mode sequencer for a cellular modem
// Assumes: network and host events are one-cycle pulses on the system clock;
//          the wake pin is asynchronous and is synchronised here
// Notes:   timers run on the retained tick input
`timescale 1ns/1ps
`include "psmc_consts.svh"
module psmc_ctrl
   import psmc_pkg::*;
(
   input  wire logic   i_sys_clk,
   input  wire logic   i_rst_n,
   input  wire logic   i_ce,
   input  wire logic   i_tick,
   input  wire logic   i_wake_pin,
   input  wire logic   i_hib_en,
   input  wire logic   i_cfg_valid,
   input  wire logic   i_cfg_psm_en,
   input  wire psmc_tmr_type i_cfg_active,
   input  wire psmc_tmr_type i_cfg_update,
   input  wire logic   i_attach_done,
   input  wire logic   i_nw_resp,
   input  wire logic   i_nw_psm_ok,
   input  wire psmc_tmr_type i_nw_active,
   input  wire psmc_tmr_type i_nw_update,
   input  wire logic   i_nw_fail,
   input  wire logic   i_traffic,
   input  wire logic   i_tx_access,
   output logic        o_attach_req,
   output logic        o_attach_psm,
   output logic        o_update_req,
   output logic        o_nw_listen,
   output logic        o_core_pwr_en,
   output logic        o_io_supply_rail_en,
   output logic        o_sim_pwr_en,
   output psmc_state_type o_state
);
   psmc_tmr_if act_if ();
   psmc_tmr_if upd_if ();

   psmc_state_type state_q;
   logic           wake_s1_q;
   logic           wake_s2_q;
   logic           psm_en_q;
   logic           attached_q;
   logic           granted_q;
   logic           grant_ld_q;   // one cycle after a grant: reload both timers
   psmc_tmr_type   act_val_q;
   psmc_tmr_type   upd_val_q;
   psmc_tmr_type   req_act_q;
   psmc_tmr_type   req_upd_q;
   logic           att_req_q;
   logic           att_psm_q;
   logic           upd_req_q;
   logic           cfg_chg;

   // wake pin synchroniser
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wake_s1_q <= 1'b0;
         wake_s2_q <= 1'b0;
      end else if (i_ce) begin
         wake_s1_q <= i_wake_pin;
         wake_s2_q <= wake_s1_q;
      end
   end

   // detects a new or changed psm request from the host
   assign cfg_chg = i_cfg_valid && i_cfg_psm_en &&
                    (!psm_en_q || i_cfg_active != req_act_q || i_cfg_update != req_upd_q);

   // host configuration capture
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         psm_en_q  <= 1'b0;
         req_act_q <= `PSMC_TMR_ZERO;
         req_upd_q <= `PSMC_TMR_ZERO;
      end else if (i_ce && i_cfg_valid) begin
         psm_en_q  <= i_cfg_psm_en;
         req_act_q <= i_cfg_active;
         req_upd_q <= i_cfg_update;
      end
   end

   // granted values held for the timers
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         granted_q  <= 1'b0;
         grant_ld_q <= 1'b0;
         act_val_q  <= `PSMC_TMR_ZERO;
         upd_val_q  <= `PSMC_TMR_ZERO;
      end else if (i_ce) begin
         grant_ld_q <= 1'b0;
         if (i_nw_resp && (state_q == PSMC_ATTACHING || state_q == PSMC_UPDATING)) begin
            granted_q <= i_nw_psm_ok && psm_en_q;
            if (i_nw_psm_ok) begin
               grant_ld_q <= 1'b1;
               act_val_q <= i_nw_active;
               upd_val_q <= i_nw_update;
            end
         end else if (i_cfg_valid && !i_cfg_psm_en) begin
            granted_q <= 1'b0;
         end
      end
   end

   // main sequencer
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q    <= PSMC_DETACHED;
         attached_q <= 1'b0;
         att_req_q  <= 1'b0;
         att_psm_q  <= 1'b0;
         upd_req_q  <= 1'b0;
      end else if (i_ce) begin
         att_req_q <= 1'b0;
         upd_req_q <= 1'b0;
         case (state_q)
            PSMC_DETACHED: begin
               att_req_q <= 1'b1;
               att_psm_q <= psm_en_q || (i_cfg_valid && i_cfg_psm_en);
               state_q   <= PSMC_ATTACHING;
            end
            PSMC_ATTACHING: begin
               if (i_attach_done || i_nw_resp) begin
                  attached_q <= 1'b1;
                  // a bare attach completion never grants power saving
                  state_q    <= (i_nw_resp && i_nw_psm_ok && psm_en_q) ?
                                PSMC_IDLE : PSMC_CONNECTED;
               end else if (i_nw_fail) begin
                  state_q <= PSMC_DETACHED;
               end
            end
            PSMC_CONNECTED: begin
               if (cfg_chg) begin
                  upd_req_q <= 1'b1;
                  state_q   <= PSMC_UPDATING;
               end
            end
            PSMC_UPDATING: begin
               if (i_nw_resp) begin
                  state_q <= (i_nw_psm_ok && psm_en_q) ? PSMC_IDLE : PSMC_CONNECTED;
               end else if (i_nw_fail || upd_if.expired) begin
                  attached_q <= 1'b0;
                  state_q    <= PSMC_DETACHED;
               end
            end
            PSMC_IDLE: begin
               if (cfg_chg) begin
                  upd_req_q <= 1'b1;
                  state_q   <= PSMC_UPDATING;
               end else if (!granted_q) begin
                  state_q <= PSMC_CONNECTED;
               end else if (act_if.expired && !i_traffic) begin
                  state_q <= i_hib_en ? PSMC_HIBERNATE : PSMC_DORMANT;
               end else if (upd_if.expired) begin
                  upd_req_q <= 1'b1;
                  state_q   <= PSMC_UPDATING;
               end
            end
            PSMC_DORMANT: begin
               if (wake_s2_q) begin
                  state_q <= PSMC_IDLE;
               end else if (upd_if.expired) begin
                  upd_req_q <= 1'b1;
                  state_q   <= PSMC_UPDATING;
               end
            end
            // hibernate leaves on the wake level alone
            PSMC_HIBERNATE: begin
               if (wake_s2_q) begin
                  state_q <= PSMC_IDLE;
               end
            end
            default: begin
               state_q <= PSMC_DETACHED;
            end
         endcase
      end
   end

   // timer control: active timer restarts on idle entry and traffic
   assign act_if.load  = (state_q != PSMC_IDLE) || i_traffic || grant_ld_q;
   assign act_if.run   = (state_q == PSMC_IDLE);
   assign act_if.value = act_val_q;
   // update timer restarts on a transmit access, an update request or a grant
   // held loaded in hibernate, so it restarts from the wake
   assign upd_if.load  = i_tx_access || upd_req_q || !granted_q || grant_ld_q ||
                         (state_q == PSMC_HIBERNATE);
   assign upd_if.run   = granted_q;
   assign upd_if.value = upd_val_q;

   psmc_timer u_act (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_ce      (i_ce),
      .i_tick    (i_tick),
      .tif       (act_if)
   );
   psmc_timer u_upd (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_ce      (i_ce),
      .i_tick    (i_tick),
      .tif       (upd_if)
   );

   // registered power and network outputs
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_nw_listen         <= 1'b0;
         o_core_pwr_en       <= 1'b1;
         o_io_supply_rail_en <= 1'b1;
         o_sim_pwr_en        <= 1'b1;
         o_state             <= PSMC_DETACHED;
      end else if (i_ce) begin
         o_nw_listen <= !(state_q == PSMC_DORMANT || state_q == PSMC_HIBERNATE);
         o_core_pwr_en <= !(state_q == PSMC_DORMANT || state_q == PSMC_HIBERNATE);
         o_io_supply_rail_en <= (state_q != PSMC_HIBERNATE);
         o_sim_pwr_en <= (state_q != PSMC_HIBERNATE);
         o_state <= state_q;
      end
   end
   assign o_attach_req = att_req_q;
   assign o_attach_psm = att_psm_q;
   assign o_update_req = upd_req_q;

   // dormant exits within three cycles of a held wake level
   wake_exit_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ce && (state_q == PSMC_DORMANT) && wake_s2_q) |=> (state_q == PSMC_IDLE || !i_ce))
      else $error("wake did not leave dormant");
   // hibernate rail off one cycle after entry
   hib_rail_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ce && state_q == PSMC_HIBERNATE) ##1 i_ce |-> !o_io_supply_rail_en)
      else $error("io rail on in hibernate");
   hib_sim_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ce && state_q == PSMC_HIBERNATE) ##1 i_ce |-> !o_sim_pwr_en)
      else $error("card powered in hibernate");
   dormant_deaf_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ce && state_q == PSMC_DORMANT) ##1 i_ce |-> !o_nw_listen)
      else $error("listening while dormant");
   timer_tau_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ce && state_q == PSMC_DORMANT && !wake_s2_q && upd_if.expired) |=> o_update_req)
      else $error("no update on timer expiry");
   idle_sleep_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ce && state_q == PSMC_IDLE && granted_q && !cfg_chg && act_if.expired && !i_traffic
       && !i_hib_en) |=> state_q == PSMC_DORMANT)
      else $error("active expiry did not sleep");
   cfg_tau_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ce && state_q == PSMC_IDLE && cfg_chg) |=> (o_update_req && state_q == PSMC_UPDATING))
      else $error("config change sent no update");
   grant_load_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ce && i_nw_resp && i_nw_psm_ok && state_q == PSMC_UPDATING) |=>
      (act_val_q == $past(i_nw_active)))
      else $error("granted value not held");
   hib_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ce && state_q == PSMC_HIBERNATE && !wake_s2_q) |=> state_q == PSMC_HIBERNATE)
      else $error("hibernate left without wake");
   fail_reattach_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ce && state_q == PSMC_UPDATING && !i_nw_resp && i_nw_fail) |=> state_q == PSMC_DETACHED)
      else $error("no re-attach on failure");
endmodule // psmc_ctrl

// file: sim/psmc_net_model.sv
// Purpose: network side model answering attach and update requests
// Assumes: requests are one-cycle pulses; answer comes after a set delay
// Notes:   value lines carry inverted data while no answer is given
`timescale 1ns/1ps
module psmc_net_model
   import psmc_pkg::*;
(
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_req,
   input  wire logic         i_silent,
   input  wire logic         i_kick,
   input  wire logic         i_ok,
   input  wire logic [3:0]   i_dly,
   input  wire psmc_tmr_type i_g_act,
   input  wire psmc_tmr_type i_g_upd,
   output logic              o_resp,
   output logic              o_psm_ok,
   output psmc_tmr_type      o_act,
   output psmc_tmr_type      o_upd
);
   logic [4:0] wait_q; // one more than the cycles left to the answer, zero when none due
   // count down from a request to its answer; a silent network drops it
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wait_q <= 5'h00;
      end else if (i_req && !i_silent) begin
         wait_q <= {1'b0, i_dly} + 5'h01;
      end else if (wait_q != 5'h00) begin
         wait_q <= wait_q - 5'h01;
      end
   end
   // answer lines; granted values differ from the requested ones
   assign o_resp   = (wait_q == 5'h01) || i_kick;
   assign o_psm_ok = o_resp ? i_ok : !i_ok;
   assign o_act    = o_resp ? i_g_act : ~i_g_act;
   assign o_upd    = o_resp ? i_g_upd : ~i_g_upd;
endmodule // psmc_net_model

// file: sim/psmc_ctrl_tb.sv
// Purpose: self-checking bench for the power saving mode controller
// Assumes: network model answers requests, bench plays the host
// Notes:   expected values come from granted timer counts in ticks
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module psmc_ctrl_tb;
   import psmc_pkg::*;
   logic i_sys_clk, i_rst_n, i_ce, i_tick, i_wake_pin, i_hib_en, i_cfg_valid, i_cfg_psm_en;
   logic i_nw_resp, i_nw_psm_ok, i_nw_fail, i_traffic, i_tx_access;
   logic o_attach_req, o_attach_psm, o_update_req, o_nw_listen, o_core_pwr_en;
   logic o_io_supply_rail_en, o_sim_pwr_en, silent, kick, ok;
   logic [3:0] dly;
   psmc_tmr_type i_cfg_active, i_cfg_update, i_nw_active, i_nw_update, g_act, g_upd;
   psmc_state_type o_state;
   int num_errors = 0, checks = 0, upd_cnt = 0, att_cnt = 0, base;

   psmc_ctrl dut_u (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_tick(i_tick),
      .i_wake_pin(i_wake_pin), .i_hib_en(i_hib_en), .i_cfg_valid(i_cfg_valid),
      .i_cfg_psm_en(i_cfg_psm_en), .i_cfg_active(i_cfg_active), .i_cfg_update(i_cfg_update),
      .i_attach_done(i_nw_resp), .i_nw_resp(i_nw_resp), .i_nw_psm_ok(i_nw_psm_ok),
      .i_nw_active(i_nw_active), .i_nw_update(i_nw_update), .i_nw_fail(i_nw_fail),
      .i_traffic(i_traffic), .i_tx_access(i_tx_access), .o_attach_req(o_attach_req),
      .o_attach_psm(o_attach_psm), .o_update_req(o_update_req), .o_nw_listen(o_nw_listen),
      .o_core_pwr_en(o_core_pwr_en), .o_io_supply_rail_en(o_io_supply_rail_en),
      .o_sim_pwr_en(o_sim_pwr_en), .o_state(o_state));

   psmc_net_model net_u (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
      .i_req(o_attach_req | o_update_req), .i_silent(silent), .i_kick(kick), .i_ok(ok),
      .i_dly(dly), .i_g_act(g_act), .i_g_upd(g_upd), .o_resp(i_nw_resp),
      .o_psm_ok(i_nw_psm_ok), .o_act(i_nw_active), .o_upd(i_nw_update));

   // clock source
   initial begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end
   // count request pulses sent to the network
   always @(posedge i_sys_clk) begin
      if (o_update_req === 1'b1) upd_cnt++;
      if (o_attach_req === 1'b1) att_cnt++;
   end

   task automatic finish_test();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
      cyc(1);
   endtask
   task automatic tick(input int n);
      repeat (n) pulse(i_tick);
   endtask
   task automatic wait_st(input psmc_state_type s, input bit neg, input int bound);
      int i;
      for (i = 0; i < bound && ((o_state === s) == neg); i++) cyc(1);
      `CHK("state", 1'b1, (o_state === s) != neg)
      if (i >= bound) finish_test();
   endtask
   task automatic tick_until(ref int c, input int old, input int bound);
      for (int i = 0; i < bound && c == old; i++) pulse(i_tick);
      `CHK("request", 1'b1, c != old)
      if (c == old) finish_test();
   endtask

   // main sequence
   initial begin
      void'($urandom(41660));
      {i_tick, i_wake_pin, i_hib_en, i_cfg_valid, i_cfg_psm_en, i_nw_fail} = '0;
      {i_traffic, i_tx_access, silent, kick, ok, i_rst_n} = '0;
      i_ce = 1'b1;
      dly = 4'($urandom_range(7, 0));
      g_act = $urandom_range(8, 3);
      g_upd = $urandom_range(60, 40);
      i_cfg_active = $urandom_range(30, 20);
      i_cfg_update = $urandom_range(90, 61);
      cyc(4);
      `CHK("state", PSMC_DETACHED, o_state)
      `CHK("listen", 1'b0, o_nw_listen)
      `CHK("core", 1'b1, o_core_pwr_en)
      cyc(1);
      i_rst_n = 1'b1;
      // attach without power saving, then enable it
      wait_st(PSMC_CONNECTED, 0, 30);
      base = upd_cnt;
      ok = 1'b1;
      i_cfg_psm_en = 1'b1;
      pulse(i_cfg_valid);
      cyc(2);
      `CHK("update", base + 1, upd_cnt)
      wait_st(PSMC_IDLE, 0, 30);
      cyc(2);
      `CHK("listen", 1'b1, o_nw_listen)
      // traffic restarts the active timer; frozen ticks are not counted
      tick(2);
      pulse(i_traffic);
      tick(int'(g_act) - 1);
      `CHK("state", PSMC_IDLE, o_state)
      i_ce = 1'b0;
      tick(int'(g_act));
      i_ce = 1'b1;
      `CHK("state", PSMC_IDLE, o_state)
      tick(1);
      wait_st(PSMC_DORMANT, 0, 4);
      cyc(3);
      `CHK("listen", 1'b0, o_nw_listen)
      `CHK("core", 1'b0, o_core_pwr_en)
      pulse(kick);
      cyc(2);
      `CHK("state", PSMC_DORMANT, o_state)
      // host wakes at a random moment
      cyc($urandom_range(9, 1));
      i_wake_pin = 1'b1;
      wait_st(PSMC_IDLE, 0, 6);
      i_wake_pin = 1'b0;
      // access restarts the update timer, expiry then sends an update
      tick(int'(g_act) - 1);
      pulse(i_tx_access);
      base = upd_cnt;
      tick(int'(g_upd) - 1);
      `CHK("update", base, upd_cnt)
      tick_until(upd_cnt, base, 2);
      wait_st(PSMC_IDLE, 0, 30);
      // changed request values are reported
      base = upd_cnt;
      i_cfg_active = i_cfg_active + 32'h1;
      pulse(i_cfg_valid);
      cyc(2);
      `CHK("update", base + 1, upd_cnt)
      wait_st(PSMC_IDLE, 0, 30);
      // hibernate: rail and card off, only the wake level resumes
      i_hib_en = 1'b1;
      tick(int'(g_act));
      wait_st(PSMC_HIBERNATE, 0, 4);
      cyc(3);
      `CHK("io_rail", 1'b0, o_io_supply_rail_en)
      `CHK("sim", 1'b0, o_sim_pwr_en)
      pulse(i_traffic);
      pulse(kick);
      `CHK("state", PSMC_HIBERNATE, o_state)
      i_wake_pin = 1'b1;
      wait_st(PSMC_HIBERNATE, 1, 6);
      `CHK("io_rail", 1'b1, o_io_supply_rail_en)
      `CHK("sim", 1'b1, o_sim_pwr_en)
      i_wake_pin = 1'b0;
      i_hib_en = 1'b0;
      // unreachable network at update expiry forces a re-attach
      silent = 1'b1;
      tick_until(upd_cnt, upd_cnt, int'(g_upd + g_act) + 4);
      tick_until(att_cnt, att_cnt, int'(g_upd) + 2);
      // reset in mid-run, power saving asked before the attach
      i_rst_n = 1'b0;
      silent = 1'b0;
      dly = 4'hF;
      cyc(5);
      i_rst_n = 1'b1;
      pulse(i_cfg_valid);
      wait_st(PSMC_ATTACHING, 0, 6);
      cyc(2);
      `CHK("attach_psm", 1'b1, o_attach_psm)
      wait_st(PSMC_IDLE, 0, 30);
      // network failure during an update forces a re-attach
      i_cfg_update = i_cfg_update + 32'h1;
      pulse(i_cfg_valid);
      pulse(i_nw_fail);
      `CHK("state", PSMC_DETACHED, o_state)
      wait_st(PSMC_IDLE, 0, 30);
      finish_test();
   end
endmodule // psmc_ctrl_tb
